// >>> hw/fbc_cycle.v
/*
 * One bus cycle on the flash pins: read or strobed write.
 * Assumes a synchronous reset copy and inputs synchronous to mclk.
 */
`timescale 1ns/1ps
`include "fbc_defs.vh"
module fbc_cycle (
   input wire mclk,
   input wire rst_n,
   input wire start,
   input wire is_write,
   input wire [7:0] wdata,
   output reg busy,
   output reg done,
   output reg sel_n,
   output reg gate_n,
   output reg wstrobe_n,
   output reg data_oe,
   output reg [7:0] data_o
);
   localparam S_IDLE = 3'b001;
   localparam S_ACT = 3'b010;
   localparam S_END = 3'b100;
   reg [2:0] state;
   reg [`FBC_CNT_W-1:0] cnt;
   reg wr;
   // last count value of each phase, cut to the counter width below
   localparam [31:0] ACC_LAST = `FBC_ACCESS_CYC - 1;
   localparam [31:0] STB_LAST = `FBC_STROBE_CYC - 1;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         cnt <= 4'h0;
         wr <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         sel_n <= 1'b1;
         gate_n <= 1'b1;
         wstrobe_n <= 1'b1;
         data_oe <= 1'b0;
         data_o <= 8'h00;
      end else begin
         done <= 1'b0;
         case (state)
            S_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  wr <= is_write;
                  sel_n <= 1'b0;
                  // read: both lows with strobe high; write: gate high, strobe low
                  gate_n <= is_write;
                  wstrobe_n <= ~is_write;
                  data_oe <= is_write;
                  data_o <= wdata;
                  cnt <= is_write ? STB_LAST[`FBC_CNT_W-1:0] : ACC_LAST[`FBC_CNT_W-1:0];
                  state <= S_ACT;
               end
            end
            S_ACT: begin
               if (cnt == 4'h0) begin
                  // strobe rise latches the data still held on the lines
                  wstrobe_n <= 1'b1;
                  gate_n <= 1'b1;
                  state <= S_END;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            S_END: begin
               sel_n <= 1'b1;
               data_oe <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

// >>> hw/fbc_defs.vh
/*
 * Constants for the host-side controller of a byte-wide bulk-erasable flash part.
 * Assumes a 40 MHz mclk; includers use the `FBC_ names below.
 */
`ifndef FBC_DEFS_VH
`define FBC_DEFS_VH
// Functional notes
// - read: select and output-gate low, write strobe high; part drives data
// - identifier mode by pins: high id level, other lines low, supply low (fbc_host drives the lowest address line from addr[0])
// - host programs whole array to 0 before a whole-chip erase (fbc_host leaves this to the caller)
// - command write: select low, output-gate high, write strobe pulsed low
// - 40h then next write programs that address and data
// - erase starts only after 20h written twice in a row
// - FFh written twice abandons a pending set-up, back to read

`define FBC_ADDR_W 18
`define FBC_DATA_W 8
`define FBC_CMD_READ 8'h00
`define FBC_CMD_IDENT 8'h90
`define FBC_CMD_ERASE 8'h20
`define FBC_CMD_ERASE_VFY 8'ha0
`define FBC_CMD_PROG 8'h40
`define FBC_CMD_PROG_VFY 8'hc0
`define FBC_CMD_RESET 8'hff
// operation codes on the user request port
`define FBC_OP_READ 3'h0
`define FBC_OP_WRITE 3'h1
`define FBC_OP_PROGRAM 3'h2
`define FBC_OP_ERASE 3'h3
`define FBC_OP_ABORT 3'h4
`define FBC_OP_IDENT 3'h5
`define FBC_OP_PIN_IDENT 3'h6
// bus timing, 25 ns period; access 170 ns rounded up
`define FBC_CLK_NS 25
`define FBC_ACCESS_NS 170
`define FBC_ACCESS_CYC ((`FBC_ACCESS_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_STROBE_NS 100
`define FBC_STROBE_CYC ((`FBC_STROBE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_CNT_W 4
`endif

// >>> hw/fbc_host.v
/*
 * Host controller for a byte-wide flash part: turns user operations into
 * command sequences and bus cycles on the part's pins.
 * Assumes the part's pins are wired directly; the part has no clock.
 */
`timescale 1ns/1ps
`include "fbc_defs.vh"
module fbc_host (
   input wire mclk,
   input wire rstn,
   input wire req,
   input wire [2:0] op,
   input wire [17:0] addr,
   input wire [7:0] wdata,
   output reg ready,
   output reg done,
   output reg [7:0] rdata,
   output reg [17:0] address_lines,
   input wire [7:0] data_lines_i,
   output reg [7:0] data_lines_o,
   output reg data_lines_oe,
   output reg sel_n,
   output reg gate_n,
   output reg wstrobe_n,
   output reg programming_supply_high,
   output reg identifier_select_line
);
   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   reg rst_a;
   reg rst_n;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   localparam S_IDLE = 4'b0001;
   localparam S_CYC = 4'b0010;
   localparam S_WAIT = 4'b0100;
   localparam S_DONE = 4'b1000;
   reg [3:0] state;
   reg [2:0] cur_op;
   reg [1:0] step;
   reg [17:0] cur_addr;
   reg [7:0] cur_data;
   reg cyc_start;
   reg cyc_write;
   reg [7:0] cyc_wdata;
   wire cyc_busy;
   wire cyc_done;
   wire c_sel_n;
   wire c_gate_n;
   wire c_wstrobe_n;
   wire c_oe;
   wire [7:0] c_do;

   fbc_cycle u_cycle (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(cyc_start),
      .is_write(cyc_write),
      .wdata(cyc_wdata),
      .busy(cyc_busy),
      .done(cyc_done),
      .sel_n(c_sel_n),
      .gate_n(c_gate_n),
      .wstrobe_n(c_wstrobe_n),
      .data_oe(c_oe),
      .data_o(c_do)
   );

   // index of the last bus cycle in each operation, which is the read if any
   function [1:0] last_step;
      input [2:0] o;
      begin
         case (o)
            `FBC_OP_PROGRAM: last_step = 2'd1;
            `FBC_OP_ERASE: last_step = 2'd1;
            `FBC_OP_ABORT: last_step = 2'd1;
            `FBC_OP_IDENT: last_step = 2'd1;
            default: last_step = 2'd0;
         endcase
      end
   endfunction

   // is bus cycle s of operation o a write, and with what data
   function step_is_write;
      input [2:0] o;
      input [1:0] s;
      begin
         case (o)
            `FBC_OP_READ: step_is_write = 1'b0;
            `FBC_OP_PIN_IDENT: step_is_write = 1'b0;
            `FBC_OP_IDENT: step_is_write = (s == 2'd0);
            default: step_is_write = 1'b1;
         endcase
      end
   endfunction

   function [7:0] step_data;
      input [2:0] o;
      input [1:0] s;
      input [7:0] d;
      begin
         case (o)
            `FBC_OP_PROGRAM: step_data = (s == 2'd0) ? `FBC_CMD_PROG : d;
            // caller must have zeroed every byte first; a full pass is too long here
            `FBC_OP_ERASE: step_data = `FBC_CMD_ERASE;
            `FBC_OP_ABORT: step_data = `FBC_CMD_RESET;
            `FBC_OP_IDENT: step_data = `FBC_CMD_IDENT;
            default: step_data = d;
         endcase
      end
   endfunction

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         cur_op <= 3'h0;
         step <= 2'd0;
         cur_addr <= 18'h00000;
         cur_data <= 8'h00;
         cyc_start <= 1'b0;
         cyc_write <= 1'b0;
         cyc_wdata <= 8'h00;
         ready <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         address_lines <= 18'h00000;
         programming_supply_high <= 1'b0;
         identifier_select_line <= 1'b0;
      end else begin
         cyc_start <= 1'b0;
         done <= 1'b0;
         case (state)
            S_IDLE: begin
               ready <= 1'b1;
               if (req) begin
                  ready <= 1'b0;
                  cur_op <= op;
                  cur_data <= wdata;
                  step <= 2'd0;
                  if (op == `FBC_OP_PIN_IDENT) begin
                     // id level on its line, others low bar the lowest, supply low
                     cur_addr <= {17'h00000, addr[0]};
                     identifier_select_line <= 1'b1;
                     programming_supply_high <= 1'b0;
                  end else begin
                     cur_addr <= addr;
                     identifier_select_line <= 1'b0;
                     // reads work either way; commands need the supply high
                     programming_supply_high <= (op != `FBC_OP_READ);
                  end
                  state <= S_CYC;
               end
            end
            S_CYC: begin
               if (!cyc_busy) begin
                  // ident command writes ignore the address; read picks the code
                  if (cur_op == `FBC_OP_IDENT)
                     address_lines <= (step == 2'd0) ? 18'h00000 : {17'h00000, cur_addr[0]};
                  else if (cur_op == `FBC_OP_PIN_IDENT)
                     address_lines <= cur_addr;
                  else
                     address_lines <= cur_addr;
                  cyc_write <= step_is_write(cur_op, step);
                  cyc_wdata <= step_data(cur_op, step, cur_data);
                  cyc_start <= 1'b1;
                  state <= S_WAIT;
               end
            end
            S_WAIT: begin
               // take the byte while gate is still low at the pins; the part
               // floats its lines from the cycle gate rises
               if (!cyc_write && c_gate_n && !gate_n)
                  rdata <= data_lines_i;
               if (cyc_done) begin
                  if (step == last_step(cur_op)) begin
                     state <= S_DONE;
                  end else begin
                     step <= step + 2'd1;
                     state <= S_CYC;
                  end
               end
            end
            S_DONE: begin
               // supply held high is harmless; a program or erase runs on internally
               identifier_select_line <= 1'b0;
               done <= 1'b1;
               ready <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pin registers fed from the cycle engine
   // ---------------------------------------------------------------
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_n <= 1'b1;
         gate_n <= 1'b1;
         wstrobe_n <= 1'b1;
         data_lines_oe <= 1'b0;
         data_lines_o <= 8'h00;
      end else begin
         sel_n <= c_sel_n;
         gate_n <= c_gate_n;
         wstrobe_n <= c_wstrobe_n;
         data_lines_oe <= c_oe;
         data_lines_o <= c_do;
      end
   end
endmodule

// >>> tb/fbc_flash_model.sv
/*
 * Behavioural model of the byte-wide flash part on the host's pins.
 * Assumes pins come straight from the host; mclk only ages the float pattern.
 */
`timescale 1ns/1ps
module fbc_flash_model #(
   parameter [7:0] MFR_ID = 8'h5a, // arbitrary value
   parameter [7:0] DEV_ID = 8'h3c // arbitrary value
) (
   input wire mclk,
   input wire [17:0] address_lines,
   input wire [7:0] data_lines_o,
   input wire data_lines_oe,
   input wire sel_n,
   input wire gate_n,
   input wire wstrobe_n,
   input wire programming_supply_high,
   input wire identifier_select_line,
   input wire main_supply_low,
   output wire [7:0] data_lines_i
);
   reg [7:0] mem [0:262143];
   integer i;
   reg [17:0] wa;
   reg [7:0] mode = 8'h00;
   reg [7:0] d;
   reg [7:0] last = 8'h00;
   reg prog_pend = 1'b0;
   reg erase_pend = 1'b0;
   reg reset_pend = 1'b0;
   // every byte starts erased
   initial for (i = 0; i < 262144; i = i + 1) mem[i] = 8'hff;
   // ----------------------------------------
   // command register
   // ----------------------------------------
   always @(negedge wstrobe_n) if (!sel_n && gate_n) wa = address_lines;
   // work finishes at the strobe rise, so later deselect cannot cut it
   always @(posedge wstrobe_n) begin
      if (!sel_n && gate_n && programming_supply_high && !main_supply_low) begin
         d = data_lines_i;
         if (prog_pend) begin
            mem[wa] = mem[wa] & d;
            prog_pend = 1'b0;
         end else begin
            if (d == 8'h20 && erase_pend)
               for (i = 0; i < 262144; i = i + 1) mem[i] = 8'hff;
            if (d == 8'hff && reset_pend) mode = 8'h00;
            erase_pend = d == 8'h20 && !erase_pend;
            reset_pend = d == 8'hff && !reset_pend;
            prog_pend = d == 8'h40;
            if (d == 8'h00 || d == 8'h90) mode = d;
         end
      end
   end
   // ----------------------------------------
   // read path; a released bus shows a moving pattern
   // ----------------------------------------
   wire id_pin = identifier_select_line && !programming_supply_high;
   wire drive = !sel_n && !gate_n && wstrobe_n;
   wire [7:0] rd = (id_pin || mode == 8'h90) ? (address_lines[0] ? DEV_ID : MFR_ID)
      : mem[address_lines];
   assign data_lines_i = data_lines_oe ? data_lines_o : drive ? rd : ~last;
   always @(posedge mclk) last <= data_lines_i;
endmodule

// >>> tb/fbc_host_props.sv
/*
 * Pin-level assertions for the flash host controller.
 * Assumes it is bound onto fbc_host and watches only its ports.
 */
`timescale 1ns/1ps
module fbc_host_props (
   input wire mclk,
   input wire rstn,
   input wire [17:0] address_lines,
   input wire [7:0] data_lines_o,
   input wire data_lines_oe,
   input wire sel_n,
   input wire gate_n,
   input wire wstrobe_n,
   input wire programming_supply_high,
   input wire identifier_select_line
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // bus rules
   // ----------------------------------------
   AST_NO_CONTEND: assert property (data_lines_oe |-> gate_n)
      else $error("host drives data while output gate low");
   AST_GATE_READ: assert property ($fell(gate_n) |-> !sel_n && wstrobe_n)
      else $error("output gate low without read pattern");
   AST_STROBE_SEL: assert property (!wstrobe_n |-> !sel_n && gate_n)
      else $error("write strobe low outside write pattern");
   AST_STROBE_WIDTH: assert property ($fell(wstrobe_n) |-> !wstrobe_n [*4] ##1 wstrobe_n)
      else $error("write strobe width wrong");
   AST_WRITE_DRIVE: assert property (!wstrobe_n |-> data_lines_oe)
      else $error("write strobe without data driven");
   AST_HOLD: assert property (!wstrobe_n && $past(!wstrobe_n) |->
      $stable(address_lines) && $stable(data_lines_o))
      else $error("address or data moved under strobe");
   AST_SUPPLY: assert property (!wstrobe_n |-> programming_supply_high)
      else $error("command write with supply low");
   AST_ID_PIN: assert property (identifier_select_line && !sel_n |->
      !programming_supply_high && address_lines[17:1] == 17'h0)
      else $error("pin identifier read with bad levels");
   cover property ($fell(wstrobe_n));
   cover property ($fell(gate_n));
   cover property ($rose(identifier_select_line));
endmodule

bind fbc_host fbc_host_props fbc_host_props_u (
   .mclk(mclk), .rstn(rstn), .address_lines(address_lines),
   .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .sel_n(sel_n),
   .gate_n(gate_n), .wstrobe_n(wstrobe_n), .programming_supply_high(programming_supply_high),
   .identifier_select_line(identifier_select_line)
);

// >>> tb/tb.sv
/*
 * Self-checking bench for fbc_host against the flash model.
 * Assumes the design's defs header is on the include path.
 */
`timescale 1ns/1ps
module tb;
   localparam [7:0] MFR = 8'h5a; // arbitrary value
   localparam [7:0] DEV = 8'h3c; // arbitrary value
   reg mclk = 1'b0;
   reg rstn = 1'b0;
   reg req = 1'b0;
   reg [2:0] op = 3'h0;
   reg [17:0] addr = 18'h0;
   reg [7:0] wdata = 8'h0;
   reg vcc_low = 1'b0;
   wire ready, done, data_lines_oe, sel_n, gate_n, wstrobe_n, vpp, id_line;
   wire [7:0] rdata, data_lines_i, data_lines_o;
   wire [17:0] address_lines;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   always #12.5 mclk = ~mclk;
   fbc_host dut_u (.mclk(mclk), .rstn(rstn), .req(req), .op(op), .addr(addr), .wdata(wdata),
      .ready(ready), .done(done), .rdata(rdata), .address_lines(address_lines),
      .data_lines_i(data_lines_i), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
      .sel_n(sel_n), .gate_n(gate_n), .wstrobe_n(wstrobe_n), .programming_supply_high(vpp),
      .identifier_select_line(id_line));
   fbc_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) flash_u (.mclk(mclk),
      .address_lines(address_lines), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
      .sel_n(sel_n), .gate_n(gate_n), .wstrobe_n(wstrobe_n), .programming_supply_high(vpp),
      .identifier_select_line(id_line), .main_supply_low(vcc_low),
      .data_lines_i(data_lines_i));
   task give_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // run is 29 operations of under 40 cycles each
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         $display("Error %0t timeout", $time);
         give_verdict;
      end
   end
   task chk(input [7:0] got, input [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task run(input [2:0] o, input [17:0] a, input [7:0] d);
      int n;
      n = 0;
      @(negedge mclk);
      while (ready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      req <= 1'b1; op <= o; addr <= a; wdata <= d;
      @(posedge mclk);
      req <= 1'b0;
      @(negedge mclk);
      while (done !== 1'b1 && n < 200) begin
         n++;
         @(negedge mclk);
      end
      if (done !== 1'b1) begin
         error_cnt++;
         $display("Error %0t no completion", $time);
      end
   endtask
   task t_program;
      run(3'h0, 18'h00123, 8'h00); chk(rdata, 8'hff);
      run(3'h2, 18'h3ffff, 8'ha5); run(3'h0, 18'h3ffff, 8'h00); chk(rdata, 8'ha5);
      run(3'h2, 18'h3ffff, 8'h0f); run(3'h0, 18'h3ffff, 8'h00); chk(rdata, 8'h05);
      run(3'h0, 18'h3fffe, 8'h00); chk(rdata, 8'hff);
   endtask
   task t_erase;
      run(3'h2, 18'h00010, 8'h00);
      run(3'h3, 18'h0, 8'h00);
      run(3'h0, 18'h3ffff, 8'h00); chk(rdata, 8'hff);
      run(3'h0, 18'h00010, 8'h00); chk(rdata, 8'hff);
   endtask
   task t_abort;
      run(3'h2, 18'h00020, 8'h00);
      run(3'h1, 18'h0, 8'h20); run(3'h4, 18'h0, 8'h00);
      run(3'h1, 18'h0, 8'h20); run(3'h0, 18'h00020, 8'h00); chk(rdata, 8'h00);
      run(3'h1, 18'h0, 8'h90); run(3'h1, 18'h0, 8'h55);
      run(3'h0, 18'h00001, 8'h00); chk(rdata, DEV);
      run(3'h4, 18'h0, 8'h00); run(3'h0, 18'h00020, 8'h00); chk(rdata, 8'h00);
   endtask
   task t_lockout;
      vcc_low <= 1'b1;
      run(3'h2, 18'h00040, 8'h00);
      vcc_low <= 1'b0;
      run(3'h0, 18'h00040, 8'h00); chk(rdata, 8'hff);
   endtask
   task t_ident;
      run(3'h5, 18'h0, 8'h00); chk(rdata, MFR);
      run(3'h5, 18'h1, 8'h00); chk(rdata, DEV);
      run(3'h1, 18'h0, 8'h00); run(3'h0, 18'h00020, 8'h00); chk(rdata, 8'h00);
      run(3'h6, 18'h0, 8'h00); chk(rdata, MFR);
      run(3'h6, 18'h1, 8'h00); chk(rdata, DEV);
      run(3'h0, 18'h00001, 8'h00); chk(rdata, 8'hff);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      t_program;
      t_erase;
      t_abort;
      t_ident;
      t_lockout;
      give_verdict;
   end
endmodule
